// ===== common/ies_defs.svh
// Register offsets, reset values and sizes of the instruction execute block.
`ifndef IES_DEFS_SVH
`define IES_DEFS_SVH

`define IES_A_INSTR 8'h00
`define IES_A_ACC 8'h04
`define IES_A_STATUS 8'h08
`define IES_A_PC 8'h0c
`define IES_A_PUSH 8'h10
`define IES_A_FADDR 8'h14
`define IES_A_FDATA 8'h18
`define IES_A_WDT 8'h1c
`define IES_A_WAKE 8'h20

`define IES_RST_ACC 8'h00
`define IES_RST_STATUS 8'h18
`define IES_RST_PC 13'h0000
`define IES_WDT_CLR 8'h00
`define IES_FILE_DEPTH 128
`define IES_STACK_DEPTH 8
`define IES_HTRANS_NONSEQ 2'h2

`endif

// ===== common/ies_pkg.sv
// Types shared by the instruction execute block and its arithmetic unit.
package ies_pkg;

  typedef enum logic [3:0] {
    OP_ADD_LITERAL = 4'h0,
    OP_ADD_ACC_FILE = 4'h1,
    OP_AND_ACC_FILE = 4'h2,
    OP_AND_LITERAL = 4'h3,
    OP_BIT_CLEAR = 4'h4,
    OP_BIT_SET = 4'h5,
    OP_ROTATE_LEFT = 4'h6,
    OP_ROTATE_RIGHT = 4'h7,
    OP_RETURN_LITERAL = 4'h8,
    OP_RETURN = 4'h9,
    OP_INTERRUPT_RETURN = 4'ha,
    OP_SLEEP = 4'hb
  } ies_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_RET2 = 2'b10,
    ST_SLEEP = 2'b11
  } ies_state_e;

  // Instruction word as written by software, high bits first.
  typedef struct packed {
    logic [7:0] lit;
    logic [6:0] faddr;
    logic [2:0] bidx;
    logic dest;
    ies_op_e op;
  } ies_instr_s;

  typedef struct packed {
    logic master_irq_enable;
    logic [1:0] spare;
    logic expiry_flag;
    logic sleep_flag;
    logic zero;
    logic nibble_overflow;
    logic carry;
  } ies_status_s;

  typedef struct packed {
    ies_op_e op;
    logic [7:0] acc;
    logic [7:0] fval;
    logic [7:0] lit;
    logic [2:0] bidx;
    logic carry;
  } ies_alu_in_s;

  typedef struct packed {
    logic [7:0] res;
    logic carry;
    logic nibble_overflow;
    logic zero;
    logic wr_c;
    logic wr_dc;
    logic wr_z;
    logic to_file;
  } ies_alu_out_s;

endpackage

// ===== hdl/ies_alu.sv
// Combinational arithmetic and logic unit of the instruction execute block.
module ies_alu (
  // Operands
  input wire ies_pkg::ies_alu_in_s a_i,
  // Result and flags
  output ies_pkg::ies_alu_out_s y_o
);

  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] mask;

  always_comb begin
    sum = 9'h000;
    low_sum = 5'h00;
    mask = 8'h01 << a_i.bidx;
    y_o = '0;
    y_o.carry = a_i.carry;
    case (a_i.op)
      ies_pkg::OP_ADD_LITERAL, ies_pkg::OP_ADD_ACC_FILE: begin
        if (a_i.op == ies_pkg::OP_ADD_LITERAL) begin
          sum = {1'b0, a_i.acc} + {1'b0, a_i.lit}; // [RQ1]
          low_sum = {1'b0, a_i.acc[3:0]} + {1'b0, a_i.lit[3:0]};
        end else begin
          sum = {1'b0, a_i.acc} + {1'b0, a_i.fval}; // [RQ2]
          low_sum = {1'b0, a_i.acc[3:0]} + {1'b0, a_i.fval[3:0]};
        end
        y_o.res = sum[7:0];
        y_o.carry = sum[8];
        y_o.nibble_overflow = low_sum[4];
        y_o.wr_c = 1'b1;
        y_o.wr_dc = 1'b1;
        y_o.wr_z = 1'b1;
      end
      ies_pkg::OP_AND_ACC_FILE: begin
        y_o.res = a_i.acc & a_i.fval; // [RQ4]
        y_o.wr_z = 1'b1;
      end
      ies_pkg::OP_AND_LITERAL: begin
        y_o.res = a_i.acc & a_i.lit; // [RQ5]
        y_o.wr_z = 1'b1;
      end
      ies_pkg::OP_BIT_CLEAR: begin
        y_o.res = a_i.fval & ~mask; // [RQ6]
        y_o.to_file = 1'b1;
      end
      ies_pkg::OP_BIT_SET: begin
        y_o.res = a_i.fval | mask; // [RQ7]
        y_o.to_file = 1'b1;
      end
      ies_pkg::OP_ROTATE_LEFT: begin
        y_o.res = {a_i.fval[6:0], a_i.carry}; // [RQ8]
        y_o.carry = a_i.fval[7];
        y_o.wr_c = 1'b1;
      end
      ies_pkg::OP_ROTATE_RIGHT: begin
        y_o.res = {a_i.carry, a_i.fval[7:1]}; // [RQ9]
        y_o.carry = a_i.fval[0];
        y_o.wr_c = 1'b1;
      end
      ies_pkg::OP_RETURN_LITERAL: begin
        y_o.res = a_i.lit; // [RQ10]
      end
      default: begin
        y_o.res = a_i.acc;
      end
    endcase
    y_o.zero = (y_o.res == 8'h00); // [RQ18]
  end

endmodule

// ===== hdl/ies_core.sv
// Instruction execute unit with AHB-Lite register access.
`include "ies_defs.svh"

// Operation
// [RQ1] add_literal adds immediate to accumulator, flags C/DC/Z
// [RQ2] add_acc_file adds accumulator and file register, C/DC/Z
// [RQ3] Destination bit selects accumulator or file register
// [RQ4] and_acc_file ANDs, updates zero only
// [RQ5] and_literal ANDs immediate into accumulator, zero only
// [RQ6] bit_clear clears indexed bit, flags untouched
// [RQ7] bit_set sets indexed bit, flags untouched
// [RQ8] rotate_left through carry to destination
// [RQ9] rotate_right through carry, only carry changes
// [RQ10] return_literal loads accumulator, flags untouched
// [RQ11] return_literal pops stack into program counter
// [RQ12] Plain return pops stack head into counter
// [RQ13] Every return takes two instruction cycles
// [RQ14] Sleep clears sleep_flag, sets expiry_flag
// [RQ15] Sleep clears watchdog counter and prescaler
// [RQ16] Then enter low-power state, clock halted
// [RQ17] interrupt_return pops stack, sets master_irq_enable
// [RQ18] Zero flag set on all-zero result
module ies_core (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Core state
  output logic sleep_o,
  output logic irq_en_o,
  output logic [12:0] pc_o
);

  ies_pkg::ies_state_e st_r, st_nxt;
  ies_pkg::ies_instr_s instr_r, instr_nxt;
  ies_pkg::ies_status_s stat_r, stat_nxt;
  ies_pkg::ies_alu_in_s alu_in;
  ies_pkg::ies_alu_out_s alu_out;
  logic [7:0] acc_r, acc_nxt;
  logic [12:0] pc_r, pc_nxt;
  logic [2:0] sp_r, sp_nxt;
  logic [12:0] stk_r [`IES_STACK_DEPTH];
  logic [12:0] stk_nxt [`IES_STACK_DEPTH];
  logic [7:0] fr_r [`IES_FILE_DEPTH];
  logic [7:0] fr_nxt [`IES_FILE_DEPTH];
  logic [6:0] fidx_r, fidx_nxt;
  logic [7:0] wdt_r, wdt_nxt;
  logic [7:0] pre_r, pre_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] waddr_r, waddr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic sleep_r, sleep_nxt;
  logic rdy_r, rdy_nxt;
  logic take, fire, push, pop, file_op, dst_file;
  logic [12:0] head;

  // ****************************************************************
  // Bus address phase and read data
  // ****************************************************************
  assign take = hsel_i && (htrans_i == `IES_HTRANS_NONSEQ) && hready_i;

  always_comb begin
    rdy_nxt = 1'b1;
    wr_pend_nxt = take && hwrite_i;
    waddr_nxt = take ? haddr_i : waddr_r;
    hrdata_nxt = 32'h0000_0000;
    if (take && !hwrite_i) begin
      case (haddr_i)
        `IES_A_INSTR: hrdata_nxt = {30'h0, sleep_r, st_r != ies_pkg::ST_IDLE};
        `IES_A_ACC: hrdata_nxt = {24'h0, acc_r};
        `IES_A_STATUS: hrdata_nxt = {24'h0, stat_r};
        `IES_A_PC: hrdata_nxt = {19'h0, pc_r};
        `IES_A_PUSH: hrdata_nxt = {16'h0, 5'h00, sp_r, 8'h00};
        `IES_A_FADDR: hrdata_nxt = {25'h0, fidx_r};
        `IES_A_FDATA: hrdata_nxt = {24'h0, fr_r[fidx_r]};
        `IES_A_WDT: hrdata_nxt = {16'h0, pre_r, wdt_r};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Execution
  // ****************************************************************
  assign fire = (st_r == ies_pkg::ST_EXEC);
  assign head = stk_r[sp_r - 3'h1];
  assign alu_in = '{op: instr_r.op, acc: acc_r, fval: fr_r[instr_r.faddr],
                    lit: instr_r.lit, bidx: instr_r.bidx, carry: stat_r.carry};
  assign file_op = (instr_r.op == ies_pkg::OP_ADD_ACC_FILE) ||
                   (instr_r.op == ies_pkg::OP_AND_ACC_FILE) ||
                   (instr_r.op == ies_pkg::OP_ROTATE_LEFT) ||
                   (instr_r.op == ies_pkg::OP_ROTATE_RIGHT);
  assign dst_file = alu_out.to_file || (file_op && instr_r.dest); // [RQ3]
  assign pop = fire && ((instr_r.op == ies_pkg::OP_RETURN_LITERAL) ||
                        (instr_r.op == ies_pkg::OP_RETURN) ||
                        (instr_r.op == ies_pkg::OP_INTERRUPT_RETURN));
  assign push = wr_pend_r && (waddr_r == `IES_A_PUSH);

  ies_alu u_alu (
    .a_i(alu_in),
    .y_o(alu_out)
  );

  // Bus writes are applied first, so an executing instruction wins any flag it touches.
  always_comb begin
    st_nxt = st_r;
    instr_nxt = instr_r;
    acc_nxt = acc_r;
    stat_nxt = stat_r;
    pc_nxt = pc_r;
    fidx_nxt = fidx_r;
    fr_nxt = fr_r;
    wdt_nxt = wdt_r;
    pre_nxt = pre_r;
    if (st_r != ies_pkg::ST_SLEEP) begin
      pre_nxt = pre_r + 8'h01;
      if (pre_r == 8'hff) begin
        wdt_nxt = wdt_r + 8'h01;
      end
    end
    if (wr_pend_r) begin
      case (waddr_r)
        `IES_A_INSTR: begin
          if (st_r == ies_pkg::ST_IDLE) begin
            instr_nxt = ies_pkg::ies_instr_s'(hwdata_i[$bits(ies_pkg::ies_instr_s)-1:0]);
            st_nxt = ies_pkg::ST_EXEC;
          end
        end
        `IES_A_ACC: acc_nxt = hwdata_i[7:0];
        `IES_A_STATUS: stat_nxt = ies_pkg::ies_status_s'(hwdata_i[7:0]);
        `IES_A_PC: pc_nxt = hwdata_i[12:0];
        `IES_A_FADDR: fidx_nxt = hwdata_i[6:0];
        `IES_A_FDATA: fr_nxt[fidx_r] = hwdata_i[7:0];
        `IES_A_WAKE: begin
          if (st_r == ies_pkg::ST_SLEEP) begin
            st_nxt = ies_pkg::ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
    case (st_r)
      ies_pkg::ST_EXEC: begin
        st_nxt = ies_pkg::ST_IDLE;
        pc_nxt = pc_r + 13'h0001;
        if (alu_out.wr_c) begin
          stat_nxt.carry = alu_out.carry; // [RQ8] [RQ9]
        end
        if (alu_out.wr_dc) begin
          stat_nxt.nibble_overflow = alu_out.nibble_overflow; // [RQ1] [RQ2]
        end
        if (alu_out.wr_z) begin
          stat_nxt.zero = alu_out.zero; // [RQ18] [RQ4] [RQ5]
        end
        case (instr_r.op)
          ies_pkg::OP_ADD_LITERAL, ies_pkg::OP_AND_LITERAL: begin
            acc_nxt = alu_out.res; // [RQ1] [RQ5]
          end
          ies_pkg::OP_RETURN_LITERAL, ies_pkg::OP_RETURN,
          ies_pkg::OP_INTERRUPT_RETURN: begin
            pc_nxt = head; // [RQ11] [RQ12] [RQ17]
            st_nxt = ies_pkg::ST_RET2; // [RQ13]
            if (instr_r.op == ies_pkg::OP_RETURN_LITERAL) begin
              acc_nxt = alu_out.res; // [RQ10]
            end
            if (instr_r.op == ies_pkg::OP_INTERRUPT_RETURN) begin
              stat_nxt.master_irq_enable = 1'b1; // [RQ17]
            end
          end
          ies_pkg::OP_SLEEP: begin
            stat_nxt.sleep_flag = 1'b0; // [RQ14]
            stat_nxt.expiry_flag = 1'b1; // [RQ14]
            wdt_nxt = `IES_WDT_CLR; // [RQ15]
            pre_nxt = `IES_WDT_CLR; // [RQ15]
            st_nxt = ies_pkg::ST_SLEEP; // [RQ16]
          end
          default: begin
            if (dst_file) begin
              fr_nxt[instr_r.faddr] = alu_out.res; // [RQ3] [RQ6] [RQ7]
            end else if (file_op) begin
              acc_nxt = alu_out.res; // [RQ3]
            end
          end
        endcase
      end
      ies_pkg::ST_RET2: st_nxt = ies_pkg::ST_IDLE; // [RQ13]
      ies_pkg::ST_IDLE, ies_pkg::ST_SLEEP: begin
      end
      default: st_nxt = ies_pkg::ST_IDLE;
    endcase
    sp_nxt = sp_r + {2'b00, push} - {2'b00, pop}; // [RQ11] [RQ12]
    sleep_nxt = (st_nxt == ies_pkg::ST_SLEEP); // [RQ16]
  end

  // Each return-stack entry is loaded only when a push lands on it.
  for (genvar i = 0; i < `IES_STACK_DEPTH; i++) begin : g_stk
    assign stk_nxt[i] = (push && (sp_r == 3'(i))) ? hwdata_i[12:0] : stk_r[i];
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        stk_r[i] <= `IES_RST_PC;
      end else begin
        stk_r[i] <= stk_nxt[i];
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= ies_pkg::ST_IDLE;
      instr_r <= '0;
      acc_r <= `IES_RST_ACC;
      stat_r <= `IES_RST_STATUS;
      pc_r <= `IES_RST_PC;
      sp_r <= 3'h0;
      fidx_r <= 7'h00;
      wdt_r <= `IES_WDT_CLR;
      pre_r <= `IES_WDT_CLR;
      wr_pend_r <= 1'b0;
      waddr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      sleep_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      instr_r <= instr_nxt;
      acc_r <= acc_nxt;
      stat_r <= stat_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      fidx_r <= fidx_nxt;
      wdt_r <= wdt_nxt;
      pre_r <= pre_nxt;
      wr_pend_r <= wr_pend_nxt;
      waddr_r <= waddr_nxt;
      hrdata_r <= hrdata_nxt;
      sleep_r <= sleep_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // The file registers carry no reset value.
  always_ff @(posedge clk_sys_i) begin
    fr_r <= fr_nxt;
  end

  assign hrdata_o = hrdata_r;
  assign hreadyout_o = rdy_r;
  assign hresp_o = 1'b0;
  assign sleep_o = sleep_r;
  assign irq_en_o = stat_r.master_irq_enable;
  assign pc_o = pc_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  property p_add_lit;
    fire && instr_r.op == ies_pkg::OP_ADD_LITERAL |=>
      acc_r == 8'($past(acc_r) + $past(instr_r.lit)) && stat_r.zero == (acc_r == 8'h00);
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("add_literal sum wrong"); // [RQ1]

  property p_dest_file;
    fire && file_op && instr_r.dest |=> $stable(acc_r);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file dest changed acc"); // [RQ3]

  property p_and_carry;
    fire && (instr_r.op == ies_pkg::OP_AND_LITERAL ||
             instr_r.op == ies_pkg::OP_AND_ACC_FILE) |=> $stable(stat_r.carry);
  endproperty
  a_and_carry: assert property (p_and_carry) else $error("and changed carry"); // [RQ4]

  property p_bit_flags;
    fire && !wr_pend_r && (instr_r.op == ies_pkg::OP_BIT_SET ||
                           instr_r.op == ies_pkg::OP_BIT_CLEAR) |=> $stable(stat_r);
  endproperty
  a_bit_flags: assert property (p_bit_flags) else $error("bit op changed flags"); // [RQ6]

  property p_rrf_carry;
    fire && instr_r.op == ies_pkg::OP_ROTATE_RIGHT |=>
      stat_r.carry == $past(fr_r[instr_r.faddr][0]);
  endproperty
  a_rrf_carry: assert property (p_rrf_carry) else $error("rotate right carry"); // [RQ9]

  property p_ret_two;
    pop |=> st_r == ies_pkg::ST_RET2 && pc_r == $past(head) ##1 st_r == ies_pkg::ST_IDLE;
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("return not two cycles"); // [RQ13]

  property p_sleep;
    fire && instr_r.op == ies_pkg::OP_SLEEP |=>
      !stat_r.sleep_flag && stat_r.expiry_flag && sleep_o && wdt_r == `IES_WDT_CLR &&
      pre_r == `IES_WDT_CLR;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong"); // [RQ14]

  property p_sleep_wdt;
    sleep_o && $past(sleep_o) |-> $stable(wdt_r) && $stable(pre_r);
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt) else $error("watchdog ran in sleep"); // [RQ16]

  property p_interrupt_return;
    fire && instr_r.op == ies_pkg::OP_INTERRUPT_RETURN |=> irq_en_o && sp_r == $past(sp_r) - 3'h1;
  endproperty
  a_interrupt_return: assert property (p_interrupt_return) else $error("interrupt_return wrong"); // [RQ17]

  c_ret_lit: cover property (fire && instr_r.op == ies_pkg::OP_RETURN_LITERAL);
  c_sleep_wake: cover property (sleep_o ##[1:100] !sleep_o);
  c_add_zero: cover property (fire && alu_out.wr_z && alu_out.zero);

endmodule

// ===== testbench/instruction_execute_subset_tb.sv
// Self-checking bench of the instruction execute block driven over its register bus.
`include "ies_defs.svh"

module instruction_execute_subset_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ********************************************************************
  // Signals, clock and design
  // ********************************************************************
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h00000000;
  logic hready_i;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic sleep_o;
  logic irq_en_o;
  logic [12:0] pc_o;
  int mismatches = 0;
  int compares = 0;
  localparam logic [6:0] FA = 7'h7f;

  assign hready_i = hreadyout_o;

  always #25 clk_sys_i = ~clk_sys_i;

  ies_core dut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .sleep_o(sleep_o), .irq_en_o(irq_en_o), .pc_o(pc_o)
  );

  // ********************************************************************
  // Checks and bus tasks
  // ********************************************************************
  task automatic conclude();
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_w(input string m, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_b(input string m, input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  // One single transfer; entered and left just after a rising edge.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
      output logic [31:0] r);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= `IES_HTRANS_NONSEQ;
    do @(posedge clk_sys_i); while (hready_i !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_sys_i); while (hready_i !== 1'b1);
    r = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask

  task automatic rdc(input string m, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 32'h00000000, x);
    chk_w(m, x, e);
  endtask

  // Issues an instruction and polls until it is done or the core sleeps.
  task automatic exec(input logic [31:0] w);
    logic [31:0] x;
    wr(`IES_A_INSTR, w);
    for (int n = 0; n < 8; n++) begin
      bus(`IES_A_INSTR, 1'b0, 32'h00000000, x);
      if (x[0] === 1'b0 || x[1] === 1'b1) break;
    end
  endtask

  function automatic logic [31:0] iw(ies_pkg::ies_op_e op, logic d, logic [2:0] b,
      logic [7:0] k);
    ies_pkg::ies_instr_s s;
    s.op = op;
    s.dest = d;
    s.bidx = b;
    s.faddr = FA;
    s.lit = k;
    return {9'h000, s};
  endfunction

  // Expected {acc, file, status} after one instruction.
  function automatic logic [23:0] model(ies_pkg::ies_op_e op, logic d, logic [2:0] b,
      logic [7:0] k, logic [7:0] a, logic [7:0] f, logic [7:0] s);
    logic [8:0] r;
    logic [7:0] o;
    logic [7:0] ea;
    logic [7:0] ef;
    logic [7:0] es;
    logic lf;
    ea = a;
    ef = f;
    es = s;
    lf = d;
    o = (op == ies_pkg::OP_ADD_LITERAL || op == ies_pkg::OP_AND_LITERAL) ? k : f;
    r = 9'h000;
    case (op)
      ies_pkg::OP_ADD_LITERAL, ies_pkg::OP_ADD_ACC_FILE: begin
        r = {1'b0, a} + {1'b0, o};
        es[0] = r[8];
        es[1] = ({1'b0, a[3:0]} + {1'b0, o[3:0]}) > 5'h0f;
        es[2] = (r[7:0] == 8'h00);
        lf = d & (op == ies_pkg::OP_ADD_ACC_FILE);
      end
      ies_pkg::OP_AND_ACC_FILE, ies_pkg::OP_AND_LITERAL: begin
        r = {1'b0, a & o};
        es[2] = (r[7:0] == 8'h00);
        lf = d & (op == ies_pkg::OP_AND_ACC_FILE);
      end
      ies_pkg::OP_BIT_CLEAR: begin
        r = {1'b0, f & ~(8'h01 << b)};
        lf = 1'b1;
      end
      ies_pkg::OP_BIT_SET: begin
        r = {1'b0, f | (8'h01 << b)};
        lf = 1'b1;
      end
      ies_pkg::OP_ROTATE_LEFT: begin
        r = {1'b0, f[6:0], s[0]};
        es[0] = f[7];
      end
      ies_pkg::OP_ROTATE_RIGHT: begin
        r = {1'b0, s[0], f[7:1]};
        es[0] = f[0];
      end
      default: begin
        r = {1'b0, k};
        lf = 1'b0;
      end
    endcase
    if (lf) begin
      ef = r[7:0];
    end else begin
      ea = r[7:0];
    end
    return {ea, ef, es};
  endfunction

  task automatic do_op(input ies_pkg::ies_op_e op, input logic d, input logic [2:0] b,
      input logic [7:0] k, input logic [7:0] a, input logic [7:0] f, input logic [7:0] s);
    logic [23:0] e;
    e = model(op, d, b, k, a, f, s);
    wr(`IES_A_ACC, {24'h000000, a});
    wr(`IES_A_STATUS, {24'h000000, s});
    wr(`IES_A_FDATA, {24'h000000, f});
    exec(iw(op, d, b, k));
    rdc("acc", `IES_A_ACC, {24'h000000, e[23:16]});
    rdc("status", `IES_A_STATUS, {24'h000000, e[7:0]});
    rdc("file", `IES_A_FDATA, {24'h000000, e[15:8]});
  endtask

  // ********************************************************************
  // Tests
  // ********************************************************************
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    conclude();
  end

  initial begin
    logic [31:0] x;
    repeat (6) @(posedge clk_sys_i);
    chk_b("ready rst", hreadyout_o, 1'b0);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rdc("acc rst", `IES_A_ACC, 32'h00000000);
    rdc("status rst", `IES_A_STATUS, 32'h00000018);
    rdc("pc rst", `IES_A_PC, 32'h00000000);
    wr(`IES_A_FADDR, {25'h0000000, FA});
    do_op(ies_pkg::OP_ADD_LITERAL, 1'b0, 3'h0, 8'h01, 8'hff, 8'h00, 8'h18);
    do_op(ies_pkg::OP_ADD_LITERAL, 1'b1, 3'h0, 8'h34, 8'h12, 8'h5a, 8'h07);
    do_op(ies_pkg::OP_ADD_LITERAL, 1'b0, 3'h0, 8'h01, 8'h0f, 8'h00, 8'h00);
    do_op(ies_pkg::OP_ADD_ACC_FILE, 1'b1, 3'h0, 8'h00, 8'h80, 8'h80, 8'h00);
    do_op(ies_pkg::OP_ADD_ACC_FILE, 1'b0, 3'h0, 8'h00, 8'h08, 8'h09, 8'h07);
    do_op(ies_pkg::OP_AND_ACC_FILE, 1'b1, 3'h0, 8'h00, 8'hf0, 8'h0f, 8'h03);
    do_op(ies_pkg::OP_AND_ACC_FILE, 1'b0, 3'h0, 8'h00, 8'h3c, 8'hf0, 8'h04);
    do_op(ies_pkg::OP_AND_LITERAL, 1'b1, 3'h0, 8'hff, 8'ha5, 8'h11, 8'h07);
    do_op(ies_pkg::OP_AND_LITERAL, 1'b0, 3'h0, 8'h00, 8'hff, 8'h11, 8'h00);
    do_op(ies_pkg::OP_BIT_CLEAR, 1'b0, 3'h7, 8'h00, 8'h00, 8'hff, 8'h07);
    do_op(ies_pkg::OP_BIT_CLEAR, 1'b0, 3'h0, 8'h00, 8'h00, 8'hff, 8'h00);
    do_op(ies_pkg::OP_BIT_SET, 1'b0, 3'h0, 8'h00, 8'h00, 8'h00, 8'h07);
    do_op(ies_pkg::OP_BIT_SET, 1'b0, 3'h7, 8'h00, 8'hff, 8'h00, 8'h00);
    do_op(ies_pkg::OP_ROTATE_LEFT, 1'b1, 3'h0, 8'h00, 8'h00, 8'h80, 8'h00);
    do_op(ies_pkg::OP_ROTATE_LEFT, 1'b0, 3'h0, 8'h00, 8'h00, 8'h55, 8'h01);
    do_op(ies_pkg::OP_ROTATE_RIGHT, 1'b0, 3'h0, 8'h00, 8'h77, 8'h01, 8'h04);
    do_op(ies_pkg::OP_ROTATE_RIGHT, 1'b1, 3'h0, 8'h00, 8'h77, 8'haa, 8'h01);
    wr(`IES_A_PUSH, 32'h00000123);
    wr(`IES_A_PUSH, 32'h00001fff);
    wr(`IES_A_PUSH, 32'h00000ace);
    do_op(ies_pkg::OP_RETURN_LITERAL, 1'b0, 3'h0, 8'hc3, 8'h00, 8'h11, 8'h07);
    chk_w("pc", {19'h00000, pc_o}, 32'h00000ace);
    exec(iw(ies_pkg::OP_RETURN, 1'b0, 3'h0, 8'h00));
    chk_w("pc", {19'h00000, pc_o}, 32'h00001fff);
    rdc("status", `IES_A_STATUS, 32'h00000007);
    exec(iw(ies_pkg::OP_INTERRUPT_RETURN, 1'b0, 3'h0, 8'h00));
    chk_w("pc", {19'h00000, pc_o}, 32'h00000123);
    chk_b("irq en", irq_en_o, 1'b1);
    rdc("status", `IES_A_STATUS, 32'h00000087);
    // A second instruction written straight after a return lands in its dummy cycle.
    wr(`IES_A_PUSH, 32'h00000042);
    wr(`IES_A_ACC, 32'h00000000);
    wr(`IES_A_INSTR, iw(ies_pkg::OP_RETURN, 1'b0, 3'h0, 8'h00));
    exec(iw(ies_pkg::OP_ADD_LITERAL, 1'b0, 3'h0, 8'h05));
    rdc("acc", `IES_A_ACC, 32'h00000000);
    chk_w("pc", {19'h00000, pc_o}, 32'h00000042);
    wr(`IES_A_INSTR, iw(ies_pkg::OP_ADD_LITERAL, 1'b0, 3'h0, 8'h01));
    exec(iw(ies_pkg::OP_ADD_LITERAL, 1'b0, 3'h0, 8'h02));
    rdc("acc", `IES_A_ACC, 32'h00000003);
    wr(`IES_A_STATUS, 32'h00000008);
    exec(iw(ies_pkg::OP_SLEEP, 1'b0, 3'h0, 8'h00));
    chk_b("sleep", sleep_o, 1'b1);
    rdc("status", `IES_A_STATUS, 32'h00000010);
    rdc("wdt", `IES_A_WDT, 32'h00000000);
    repeat (20) @(posedge clk_sys_i);
    rdc("wdt", `IES_A_WDT, 32'h00000000);
    wr(`IES_A_INSTR, iw(ies_pkg::OP_ADD_LITERAL, 1'b0, 3'h0, 8'h09));
    rdc("acc", `IES_A_ACC, 32'h00000003);
    chk_b("sleep", sleep_o, 1'b1);
    wr(`IES_A_WAKE, 32'h00000001);
    @(posedge clk_sys_i);
    chk_b("wake", sleep_o, 1'b0);
    wr(8'h24, 32'hffffffff);
    rdc("unmapped", 8'h24, 32'h00000000);
    chk_b("resp", hresp_o, 1'b0);
    conclude();
  end
endmodule
